// ==== logic/common_cmd_pkg.sv ====
package common_cmd_pkg;

  // decoded common commands arriving from the command parser
  typedef enum logic [3:0] {
    CMD_NONE,
    CMD_RESET,
    CMD_TRIGGER,
    CMD_CLEAR_STATUS,
    CMD_IDENT_Q,
    CMD_SELFTEST_Q,
    CMD_EVT_ENABLE,
    CMD_EVT_ENABLE_Q,
    CMD_SRQ_ENABLE,
    CMD_SRQ_ENABLE_Q,
    CMD_EVT_STATUS_Q,
    CMD_STATUS_BYTE_Q,
    CMD_OPC,
    CMD_OPC_Q
  } cmd_type;

  typedef struct packed {
    logic valid;
    cmd_type code;
    logic [7:0] arg;
  } cmd_req_type;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } out_byte_type;

  // event status bit positions
  localparam int ESR_PON = 7;
  localparam int ESR_URQ = 6;
  localparam int ESR_CME = 5;
  localparam int ESR_EXE = 4;
  localparam int ESR_DDE = 3;
  localparam int ESR_QYE = 2;
  localparam int ESR_RQC = 1;
  localparam int ESR_OPC = 0;

  // status byte bit positions
  localparam int STB_OSS = 7;
  localparam int STB_RQS = 6;
  localparam int STB_ESB = 5;
  localparam int STB_MAV = 4;

  localparam logic [7:0] ESE_RESET = 8'h00;
  localparam logic [7:0] SRE_RESET = 8'h00;
  localparam logic [7:0] ESR_RESET = 8'h80;
  localparam logic [7:0] STB_LOW_MASK = 8'hf0;

  localparam logic [7:0] CHAR_ZERO = 8'h30;
  localparam logic [7:0] CHAR_ONE = 8'h31;
  localparam logic [7:0] CHAR_COMMA = 8'h2c;
  localparam logic [7:0] CHAR_NL = 8'h0a;

  // identity strings, arbitrary neutral values
  localparam int ID_LEN = 14;
  localparam logic [8*ID_LEN-1:0] ID_TEXT = "ACME,MDL1,V0.1";

  localparam int MSG_MAX = 16;
  localparam logic [4:0] MSG_CNT_W0 = 5'h00;

endpackage : common_cmd_pkg

// ==== logic/nr1_formatter.sv ====
`timescale 1ns/1ps
// combinational byte to three-digit decimal, leading zeros suppressed
module nr1_formatter
  import common_cmd_pkg::*;
(
  input wire logic [7:0] value_i,
  output logic [7:0] d2_o,
  output logic [7:0] d1_o,
  output logic [7:0] d0_o,
  output logic [1:0] len_o
);
  logic [7:0] h;
  logic [7:0] t;
  logic [7:0] o;

  always_comb begin
    h = value_i / 8'd100;
    t = (value_i / 8'd10) % 8'd10;
    o = value_i % 8'd10;
    d2_o = CHAR_ZERO + h;
    d1_o = CHAR_ZERO + t;
    d0_o = CHAR_ZERO + o;
    if (h != 8'h00) begin
      len_o = 2'd3;
    end else if (t != 8'h00) begin
      len_o = 2'd2;
    end else begin
      len_o = 2'd1;
    end
  end
endmodule : nr1_formatter

// ==== logic/common_command_status_unit.sv ====
`timescale 1ns/1ps
module common_command_status_unit
  import common_cmd_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // decoded command from the parser
  input wire cmd_req_type cmd_i,
  output logic cmd_ready_o,
  // event sources from the instrument
  input wire logic [7:0] event_set_i,
  input wire logic oper_summary_i,
  // measurement engine
  output logic meas_start_o,
  input wire logic meas_busy_i,
  input wire logic meas_done_i,
  input wire logic [7:0] meas_result_i,
  // self test engine
  output logic selftest_start_o,
  input wire logic selftest_done_i,
  input wire logic [7:0] selftest_errsum_i,
  // output buffer
  output out_byte_type out_o,
  input wire logic out_ready_i,
  input wire logic out_empty_i,
  // instrument-wide reset and status view
  output logic inst_reset_o,
  output logic [7:0] esr_o,
  output logic [7:0] stb_o,
  output logic srq_o
);

  typedef enum {
    ST_IDLE,
    ST_WAIT_MEAS,
    ST_WAIT_TEST,
    ST_WAIT_OPC,
    ST_SEND
  } state_type;

  state_type state_q, state_d;
  logic [7:0] ese_q, ese_d;
  logic [7:0] sre_q, sre_d;
  logic [7:0] esr_q, esr_d;
  logic opc_armed_q, opc_armed_d;
  logic [8*MSG_MAX-1:0] msg_q, msg_d;
  logic [4:0] len_q, len_d;
  logic [4:0] idx_q, idx_d;
  out_byte_type out_q, out_d;
  logic meas_start_q, meas_start_d;
  logic test_start_q, test_start_d;
  logic inst_reset_q, inst_reset_d;
  logic [7:0] stb_q, stb_d;
  logic srq_q, srq_d;
  // ready is kept in its own flop so the port needs no decode
  logic ready_q, ready_d;

  logic [7:0] fmt_val;
  logic [7:0] fd2, fd1, fd0;
  logic [1:0] flen;
  logic [7:0] stb_now;
  logic idle_ops;

  nr1_formatter u_fmt (
    .value_i(fmt_val),
    .d2_o(fd2),
    .d1_o(fd1),
    .d0_o(fd0),
    .len_o(flen)
  );

  // no pending measurement and no trigger from this unit still waiting in ST_WAIT_MEAS
  assign idle_ops = !meas_busy_i && state_q != ST_WAIT_MEAS;

  always_comb begin
    stb_now = 8'h00;
    stb_now[STB_OSS] = oper_summary_i;
    stb_now[STB_ESB] = |(esr_q & ese_q);
    stb_now[STB_MAV] = !out_empty_i || out_q.valid || state_q == ST_SEND;
    stb_now[STB_RQS] = |(stb_now & sre_q & ~(8'h01 << STB_RQS));
    stb_now = stb_now & STB_LOW_MASK;
  end

  // pick the value to print in decimal; ST_WAIT_MEAS and ST_WAIT_TEST own the mux because
  // the parser may already show its next code while a result is pending
  always_comb begin
    if (state_q == ST_WAIT_MEAS) begin
      fmt_val = meas_result_i;
    end else if (state_q == ST_WAIT_TEST) begin
      fmt_val = selftest_errsum_i;
    end else begin
      case (cmd_i.code)
        CMD_EVT_ENABLE_Q: fmt_val = ese_q;
        CMD_SRQ_ENABLE_Q: fmt_val = sre_q;
        CMD_EVT_STATUS_Q: fmt_val = esr_q;
        CMD_STATUS_BYTE_Q: fmt_val = stb_now;
        default: fmt_val = 8'h00;
      endcase
    end
  end

  // loads the formatted number plus newline into the message shift buffer
  function automatic logic [8*MSG_MAX-1:0] num_msg(input logic [7:0] a, input logic [7:0] b,
                                                   input logic [7:0] c, input logic [1:0] n);
    logic [8*MSG_MAX-1:0] m;
    m = '0;
    if (n == 2'd3) begin
      m[8*MSG_MAX-1 -: 32] = {a, b, c, CHAR_NL};
    end else if (n == 2'd2) begin
      m[8*MSG_MAX-1 -: 24] = {b, c, CHAR_NL};
    end else begin
      m[8*MSG_MAX-1 -: 16] = {c, CHAR_NL};
    end
    return m;
  endfunction : num_msg

  always_comb begin
    state_d = state_q;
    ese_d = ese_q;
    sre_d = sre_q;
    esr_d = esr_q;
    opc_armed_d = opc_armed_q;
    msg_d = msg_q;
    len_d = len_q;
    idx_d = idx_q;
    out_d = out_q;
    meas_start_d = 1'b0;
    test_start_d = 1'b0;
    inst_reset_d = 1'b0;

    if (out_q.valid && out_ready_i) begin
      out_d.valid = 1'b0;
    end

    case (state_q)
      ST_IDLE: begin
        if (cmd_i.valid) begin
          case (cmd_i.code)
            CMD_RESET: begin
              inst_reset_d = 1'b1;
              ese_d = ESE_RESET;
              sre_d = SRE_RESET;
              opc_armed_d = 1'b0;
            end
            CMD_TRIGGER: begin
              meas_start_d = 1'b1;
              state_d = ST_WAIT_MEAS;
            end
            CMD_CLEAR_STATUS: begin
              esr_d = 8'h00;
              opc_armed_d = 1'b0;
            end
            CMD_IDENT_Q: begin
              msg_d = '0;
              msg_d[8*MSG_MAX-1 -: 8*(ID_LEN+1)] = {ID_TEXT, CHAR_NL};
              len_d = 5'(ID_LEN + 1);
              idx_d = MSG_CNT_W0;
              state_d = ST_SEND;
            end
            CMD_SELFTEST_Q: begin
              test_start_d = 1'b1;
              state_d = ST_WAIT_TEST;
            end
            CMD_EVT_ENABLE: ese_d = cmd_i.arg;
            CMD_SRQ_ENABLE: sre_d = cmd_i.arg;
            CMD_EVT_ENABLE_Q, CMD_SRQ_ENABLE_Q, CMD_STATUS_BYTE_Q, CMD_EVT_STATUS_Q: begin
              msg_d = num_msg(fd2, fd1, fd0, flen);
              len_d = 5'(flen) + 5'd1;
              idx_d = MSG_CNT_W0;
              state_d = ST_SEND;
              // reading event status clears it, as query-to-clear
              if (cmd_i.code == CMD_EVT_STATUS_Q) begin
                esr_d = 8'h00;
              end
            end
            CMD_OPC: opc_armed_d = 1'b1;
            CMD_OPC_Q: state_d = ST_WAIT_OPC;
            default: begin
            end
          endcase
        end
      end
      ST_WAIT_MEAS: begin
        if (meas_done_i) begin
          msg_d = num_msg(fd2, fd1, fd0, flen);
          len_d = 5'(flen) + 5'd1;
          idx_d = MSG_CNT_W0;
          state_d = ST_SEND;
        end
      end
      ST_WAIT_TEST: begin
        if (selftest_done_i) begin
          msg_d = num_msg(fd2, fd1, fd0, flen);
          len_d = 5'(flen) + 5'd1;
          idx_d = MSG_CNT_W0;
          state_d = ST_SEND;
        end
      end
      ST_WAIT_OPC: begin
        if (!meas_busy_i) begin
          msg_d = '0;
          msg_d[8*MSG_MAX-1 -: 16] = {CHAR_ONE, CHAR_NL};
          len_d = 5'd2;
          idx_d = MSG_CNT_W0;
          state_d = ST_SEND;
        end
      end
      ST_SEND: begin
        if (!out_d.valid) begin
          out_d.valid = 1'b1;
          out_d.data = msg_q[8*MSG_MAX-1 -: 8];
          out_d.last = (idx_q + 5'd1 == len_q);
          msg_d = msg_q << 8;
          idx_d = idx_q + 5'd1;
          if (idx_q + 5'd1 == len_q) begin
            state_d = ST_IDLE;
          end
        end
      end
      default: state_d = ST_IDLE;
    endcase

    // completion is reported only once nothing measures any more
    if (opc_armed_d && idle_ops && state_q != ST_WAIT_MEAS) begin
      esr_d[ESR_OPC] = 1'b1;
      opc_armed_d = 1'b0;
    end
    // hardware events win over any clear in the same cycle
    esr_d = esr_d | event_set_i;

    stb_d = stb_now;
    srq_d = stb_now[STB_RQS];
    // follows the next state, so ready drops in the cycle after a take that leaves ST_IDLE
    ready_d = (state_d == ST_IDLE);
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      ese_q <= ESE_RESET;
      sre_q <= SRE_RESET;
      esr_q <= ESR_RESET;
      opc_armed_q <= 1'b0;
      msg_q <= '0;
      len_q <= MSG_CNT_W0;
      idx_q <= MSG_CNT_W0;
      out_q <= '0;
      meas_start_q <= 1'b0;
      test_start_q <= 1'b0;
      inst_reset_q <= 1'b0;
      stb_q <= 8'h00;
      srq_q <= 1'b0;
      ready_q <= 1'b1;
    end else begin
      state_q <= state_d;
      ese_q <= ese_d;
      sre_q <= sre_d;
      esr_q <= esr_d;
      opc_armed_q <= opc_armed_d;
      msg_q <= msg_d;
      len_q <= len_d;
      idx_q <= idx_d;
      out_q <= out_d;
      meas_start_q <= meas_start_d;
      test_start_q <= test_start_d;
      inst_reset_q <= inst_reset_d;
      stb_q <= stb_d;
      srq_q <= srq_d;
      ready_q <= ready_d;
    end
  end

  always_comb begin
    cmd_ready_o = ready_q;
    meas_start_o = meas_start_q;
    selftest_start_o = test_start_q;
    out_o = out_q;
    inst_reset_o = inst_reset_q;
    esr_o = esr_q;
    stb_o = stb_q;
    srq_o = srq_q;
  end

endmodule : common_command_status_unit

// ==== test/common_command_status_unit_sva.sv ====
`timescale 1ns/1ps
module common_command_status_unit_chk
  import common_cmd_pkg::*;
(
  // clock and command side
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire cmd_req_type cmd_i,
  input wire logic cmd_ready_o,
  input wire logic [7:0] event_set_i,
  input wire logic oper_summary_i,
  // outputs watched
  input wire logic meas_start_o,
  input wire logic selftest_start_o,
  input wire out_byte_type out_o,
  input wire logic out_ready_i,
  input wire logic inst_reset_o,
  input wire logic [7:0] esr_o,
  input wire logic [7:0] stb_o,
  input wire logic srq_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic tk;
  assign tk = cmd_i.valid && cmd_ready_o;
  a_stb_low_zero: assert property (stb_o[3:0] == 4'h0)
    else $error("status byte low bits set");
  a_oss_follows: assert property (stb_o[7] == $past(oper_summary_i))
    else $error("operation summary bit wrong");
  a_srq_is_rqs: assert property (srq_o == stb_o[6])
    else $error("service request differs from status bit");
  a_rqs_has_cause: assert property (srq_o |->
    stb_o[STB_OSS] || stb_o[STB_ESB] || stb_o[STB_MAV])
    else $error("service request without a summary bit");
  a_event_latched: assert property (|event_set_i |=>
    (esr_o & $past(event_set_i)) == $past(event_set_i))
    else $error("event not latched");
  a_clear_status: assert property (tk && cmd_i.code == CMD_CLEAR_STATUS &&
    event_set_i == 8'h00 |=> esr_o == 8'h00)
    else $error("event status not cleared");
  a_reset_pulse: assert property (tk && cmd_i.code == CMD_RESET |=> inst_reset_o)
    else $error("no instrument reset");
  a_trig_start: assert property (tk && cmd_i.code == CMD_TRIGGER |=>
    meas_start_o ##1 !meas_start_o)
    else $error("no single measurement start");
  a_selftest_go: assert property (tk && cmd_i.code == CMD_SELFTEST_Q |=> selftest_start_o)
    else $error("no self test start");
  a_out_hold: assert property (out_o.valid && !out_ready_i |=> out_o.valid && $stable(out_o.data))
    else $error("output byte dropped");
  c_trigger: cover property (tk && cmd_i.code == CMD_TRIGGER);
  c_opc_query: cover property (tk && cmd_i.code == CMD_OPC_Q);
  c_srq: cover property ($rose(srq_o));
endmodule : common_command_status_unit_chk
bind common_command_status_unit common_command_status_unit_chk u_chk (.*);

// ==== test/cmd_far_model.sv ====
`timescale 1ns/1ps
module cmd_far_model
  import common_cmd_pkg::*;
#(
  parameter int LAT = 6,
  parameter logic [7:0] RES = 8'h2a
) (
  // bench control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic stall_i,
  input wire logic hold_i,
  input wire logic [7:0] st_sum_i,
  // block side
  input wire logic meas_start_i,
  input wire logic st_start_i,
  input wire out_byte_type out_i,
  output logic busy_o,
  output logic done_o,
  output logic [7:0] result_o,
  output logic st_done_o,
  output logic [7:0] st_sum_o,
  output logic ready_o,
  output logic empty_o
);
  int m_cnt = 0;
  int s_cnt = 0;
  logic [7:0] rx[$];
  logic lq[$];
  assign busy_o = hold_i || m_cnt != 0;
  // garbled outside the done pulse so a stale value cannot pass
  assign result_o = done_o ? RES : ~RES;
  assign st_sum_o = st_done_o ? st_sum_i : ~st_sum_i;
  assign ready_o = !stall_i;
  always @(posedge clk_i) begin
    done_o <= !rst_i && m_cnt == 1;
    st_done_o <= !rst_i && s_cnt == 1;
    if (out_i.valid && ready_o) begin
      rx.push_back(out_i.data);
      lq.push_back(out_i.last);
    end
    empty_o <= rx.size() == 0;
    m_cnt <= rst_i ? 0 : meas_start_i ? LAT : (m_cnt > 0 ? m_cnt - 1 : 0);
    s_cnt <= rst_i ? 0 : st_start_i ? LAT : (s_cnt > 0 ? s_cnt - 1 : 0);
  end
endmodule : cmd_far_model

// ==== test/tb_common_command_status_unit.sv ====
`timescale 1ns/1ps
module tb_common_command_status_unit;
  import common_cmd_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  cmd_req_type cmd = '0;
  logic [7:0] ev = 8'h00;
  logic [7:0] sum = 8'h00;
  logic oper = 1'b0;
  logic stall = 1'b0;
  logic hold = 1'b0;
  logic rdy, ms, mb, md, ss, sd, ordy, oemp, irst, srq;
  logic [7:0] mr, sr, standard_event_status, stb;
  out_byte_type ob;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #25 clk = ~clk;
  common_command_status_unit u_dut (.ref_clk_i(clk), .rst_i(rst), .cmd_i(cmd),
    .cmd_ready_o(rdy), .event_set_i(ev), .oper_summary_i(oper), .meas_start_o(ms),
    .meas_busy_i(mb), .meas_done_i(md), .meas_result_i(mr), .selftest_start_o(ss),
    .selftest_done_i(sd), .selftest_errsum_i(sr), .out_o(ob), .out_ready_i(ordy),
    .out_empty_i(oemp), .inst_reset_o(irst), .esr_o(standard_event_status), .stb_o(stb), .srq_o(srq));
  cmd_far_model u_far (.clk_i(clk), .rst_i(rst), .stall_i(stall), .hold_i(hold),
    .st_sum_i(sum), .meas_start_i(ms), .st_start_i(ss), .out_i(ob), .busy_o(mb),
    .done_o(md), .result_o(mr), .st_done_o(sd), .st_sum_o(sr), .ready_o(ordy),
    .empty_o(oemp));
  task automatic wrap_up;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  task automatic check(logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic issue(cmd_type c, logic [7:0] a = 8'h00);
    tick(1);
    // ready is a register, so a high level seen now still stands at the next edge
    while (rdy !== 1'b1) tick(1);
    cmd = '{1'b1, c, a};
    tick(1);
    cmd.valid = 1'b0;
  endtask : issue
  task automatic reply(string s);
    s = {s, "\n"};
    while (u_far.rx.size() < s.len()) tick(1);
    foreach (s[i]) begin
      check(u_far.rx[i], s[i]);
      check({7'h00, u_far.lq[i]}, {7'h00, i == s.len() - 1});
    end
    u_far.rx.delete();
    u_far.lq.delete();
    tick(3);
  endtask : reply
  task automatic t_masks;
    check(standard_event_status, 8'h80);
    issue(CMD_EVT_ENABLE_Q);
    reply("0");
    issue(CMD_EVT_ENABLE, 8'hff);
    issue(CMD_EVT_ENABLE_Q);
    reply("255");
    issue(CMD_SRQ_ENABLE, 8'h30);
    issue(CMD_SRQ_ENABLE_Q);
    reply("48");
  endtask : t_masks
  task automatic t_events;
    issue(CMD_EVT_ENABLE, 8'h10);
    issue(CMD_SRQ_ENABLE, 8'h20);
    ev = 8'h10;
    tick(1);
    ev = 8'h00;
    tick(3);
    check(standard_event_status, 8'h90);
    check(stb, 8'h60);
    check({7'h00, srq}, 8'h01);
    issue(CMD_EVT_STATUS_Q);
    reply("144");
    ev = 8'h0c;
    tick(1);
    ev = 8'h00;
    issue(CMD_CLEAR_STATUS);
    tick(3);
    check(standard_event_status, 8'h00);
    check(stb, 8'h00);
  endtask : t_events
  task automatic t_stb;
    oper = 1'b1;
    repeat (2) begin
      issue(CMD_STATUS_BYTE_Q);
      reply("128");
    end
    check(stb, 8'h80);
    oper = 1'b0;
  endtask : t_stb
  task automatic t_meas;
    logic [7:0] sums[2] = '{8'h00, 8'hff};
    issue(CMD_TRIGGER);
    reply("42");
    foreach (sums[i]) begin
      sum = sums[i];
      issue(CMD_SELFTEST_Q);
      reply($sformatf("%0d", sums[i]));
    end
    stall = 1'b1;
    issue(CMD_IDENT_Q);
    tick(20);
    stall = 1'b0;
    reply(string'(ID_TEXT));
  endtask : t_meas
  task automatic t_opc;
    hold = 1'b1;
    issue(CMD_OPC);
    tick(4);
    check({7'h00, standard_event_status[0]}, 8'h00);
    hold = 1'b0;
    tick(4);
    check({7'h00, standard_event_status[0]}, 8'h01);
    hold = 1'b1;
    issue(CMD_OPC_Q);
    tick(8);
    check(8'(u_far.rx.size()), 8'h00);
    hold = 1'b0;
    reply("1");
  endtask : t_opc
  task automatic t_reset;
    issue(CMD_EVT_ENABLE, 8'h07);
    issue(CMD_RESET);
    tick(3);
    issue(CMD_EVT_ENABLE_Q);
    reply("0");
    issue(CMD_SRQ_ENABLE_Q);
    reply("0");
  endtask : t_reset
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      wrap_up();
    end
  end
  initial begin
    tick(2);
    rst = 1'b0;
    t_masks();
    t_events();
    t_stb();
    t_meas();
    t_opc();
    t_reset();
    wrap_up();
  end
endmodule : tb_common_command_status_unit
